// ===== common/nor_pin_map.vh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes: Byte addresses below are used directly by the decoder.
`ifndef NOR_PIN_MAP_VH
`define NOR_PIN_MAP_VH

`define CTRL_OFS 8'h00
`define CONFIG_OFS 8'h04
`define RXDATA_OFS 8'h08
`define TXDATA_OFS 8'h0c
`define STATUS_OFS 8'h10
`define PROBE_OFS 8'h14

`define CTRL_RESET 4'h0
`define CONFIG_RESET 9'h000
`define CTRL_MODE_LSB 0
`define CTRL_TXEN_BIT 2
`define CTRL_BUSY_BIT 3
`define CFG_QE_BIT 0
`define CFG_LOCK_LSB 1
`define CFG_CMP_BIT 3
`define CFG_SEC_BIT 4
`define CFG_TB_BIT 5
`define CFG_BP_LSB 6
`define ST_OVR_BIT 5
`define PROBE_BLOCK_BIT 31

`define MODE_SINGLE 2'h0
`define MODE_DUAL 2'h1
`define MODE_QUAD 2'h2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_HZ 25000000
`define WRITE_READY_MS 5
// Five milliseconds of 25 MHz clocks, sized for the 24-bit counter.
`define WRITE_READY_CYC 24'h01e848
`define SECTORS_TOTAL 8'h80
`define SECTORS_PER_BLOCK 8'h10

`endif

// ===== design/pin_sync.v
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is an independent level.
// Notes: The first flop feeds only the second flop.
`timescale 1ns/1ns
module pin_sync #(
  parameter W = 6
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // pin_sync

// ===== design/region_protect.v
// Purpose: Decides whether an array address falls in the protected region.
// Assumes: 512KB array of 128 sectors of 4KB, 64KB blocks.
// Notes: Bottom region when top_bottom_select is 1, top region otherwise.
`timescale 1ns/1ns
`include "nor_pin_map.vh"
module region_protect (
  input wire [18:0] addr_in,
  input wire complement_protect_in,
  input wire sector_granular_protect_in,
  input wire top_bottom_select_in,
  input wire [2:0] block_protect_level_in,
  output wire hit_out
);
  reg [7:0] span;
  reg in_region;
  wire [7:0] sector;

  assign sector = {1'b0, addr_in[18:12]};

  always @* begin
    span = 8'h00;
    if (block_protect_level_in != 3'h0) begin
      if (sector_granular_protect_in) begin
        span = (block_protect_level_in >= 3'h4) ? 8'h08 :
          (8'h01 << (block_protect_level_in - 3'h1));
      end else begin
        span = (block_protect_level_in >= 3'h4) ? `SECTORS_TOTAL :
          (`SECTORS_PER_BLOCK << (block_protect_level_in - 3'h1));
      end
    end
    if (top_bottom_select_in) begin
      in_region = sector < span;
    end else begin
      in_region = sector >= (`SECTORS_TOTAL - span);
    end
  end

  assign hit_out = in_region ^ complement_protect_in;
endmodule // region_protect

// ===== design/serial_nor_pin_interface.v
// Purpose: Pin front end of a serial NOR flash with an AXI4-Lite view for the core.
// Assumes: Serial clock well below clk_sys_in/4; pins sampled through two flops.
// Notes: The core fills TXDATA and drains RXDATA; the first byte of a frame is the
//   instruction and always arrives on one lane.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "nor_pin_map.vh"
module serial_nor_pin_interface #(
  parameter [23:0] WRITE_READY_CYCLES = `WRITE_READY_CYC
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire select_n_pin_in,
  input wire sclk_pin_in,
  input wire [3:0] io_lane_in,
  output reg [3:0] io_lane_out,
  output reg [3:0] io_lane_oe_out,
  input wire [7:0] awaddr_in,
  input wire awvalid_in,
  output reg awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output reg wready_out,
  output reg [1:0] bresp_out,
  output reg bvalid_out,
  input wire bready_in,
  input wire [7:0] araddr_in,
  input wire arvalid_in,
  output reg arready_out,
  output reg [31:0] rdata_out,
  output reg [1:0] rresp_out,
  output reg rvalid_out,
  input wire rready_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Lane width in bits per clock edge; shared by the receive and send paths.
  function [3:0] lane_step;
    input [1:0] mode;
    begin
      if (mode == `MODE_QUAD) begin
        lane_step = 4'h4;
      end else if (mode == `MODE_DUAL) begin
        lane_step = 4'h2;
      end else begin
        lane_step = 4'h1;
      end
    end
  endfunction

  function [31:0] merge_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge_strb = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection.
  wire [5:0] pins_s;
  wire sel_s;
  wire sclk_s;
  wire [3:0] io_s;
  reg sclk_d_reg;
  reg sel_d_reg;

  pin_sync #(.W(6)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({select_n_pin_in, sclk_pin_in, io_lane_in}),
    .sync_out(pins_s)
  );

  assign sel_s = ~pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];

  reg [3:0] ctrl_reg;
  reg [8:0] cfg_reg;
  wire qe;
  wire wp_act;
  wire pause_act;
  wire rise;
  wire fall;
  wire sel_fall;
  reg armed_reg;
  wire active;

  assign qe = cfg_reg[`CFG_QE_BIT];
  assign wp_act = ~qe & ~io_s[2];
  assign pause_act = sel_s & ~qe & ~io_s[3];
  assign rise = sclk_s & ~sclk_d_reg;
  assign fall = ~sclk_s & sclk_d_reg;
  assign sel_fall = sel_s & ~sel_d_reg;
  // Edges are ignored while paused, so counters hold still.
  assign active = sel_s & armed_reg & ~pause_act;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d_reg <= 1'b0;
      sel_d_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      sel_d_reg <= sel_s;
      if (sel_fall) begin
        armed_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up write delay.
  reg [23:0] wr_cnt_reg;
  reg wr_ready_reg;

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_cnt_reg <= 24'h000000;
      wr_ready_reg <= 1'b0;
    end else if (!wr_ready_reg) begin
      wr_cnt_reg <= wr_cnt_reg + 24'h000001;
      if (wr_cnt_reg + 24'h000001 >= WRITE_READY_CYCLES) begin
        wr_ready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift engine.
  wire [1:0] mode_req;
  wire [1:0] data_mode;
  wire [1:0] cur_mode;
  wire [3:0] step;
  wire tx_en;
  reg first_reg;
  reg [7:0] rx_sh_reg;
  reg [7:0] rx_sh_next;
  reg [3:0] rx_cnt_reg;
  wire [3:0] rx_cnt_next;
  reg [7:0] tx_sh_reg;
  reg [3:0] tx_cnt_reg;
  reg [7:0] tx_data_reg;
  wire [7:0] tx_word;
  reg [7:0] rx_data_reg;
  reg rx_first_reg;
  reg rx_early_reg;
  reg rx_valid_reg;
  reg overrun_reg;
  wire byte_done;
  wire rx_read;
  wire ovr_clear;
  reg [3:0] oe_next;

  assign mode_req = ctrl_reg[`CTRL_MODE_LSB +: 2];
  // Quad requests fall back to one lane unless quad enable is set.
  assign data_mode = (mode_req == `MODE_QUAD && !qe) ? `MODE_SINGLE :
    (mode_req == 2'h3 ? `MODE_SINGLE : mode_req);
  assign cur_mode = first_reg ? `MODE_SINGLE : data_mode;
  assign step = lane_step(cur_mode);
  assign tx_en = ctrl_reg[`CTRL_TXEN_BIT];
  assign rx_cnt_next = rx_cnt_reg + step;
  assign byte_done = active & rise & (rx_cnt_next == 4'h8);
  assign tx_word = (tx_cnt_reg == 4'h0) ? tx_data_reg : tx_sh_reg;

  always @* begin
    if (cur_mode == `MODE_QUAD) begin
      rx_sh_next = {rx_sh_reg[3:0], io_s[3:0]};
    end else if (cur_mode == `MODE_DUAL) begin
      rx_sh_next = {rx_sh_reg[5:0], io_s[1:0]};
    end else begin
      rx_sh_next = {rx_sh_reg[6:0], io_s[0]};
    end
  end

  always @* begin
    if (data_mode == `MODE_QUAD) begin
      oe_next = 4'hf;
    end else if (data_mode == `MODE_DUAL) begin
      oe_next = 4'h3;
    end else begin
      oe_next = 4'h2;
    end
    if (!(active && tx_en && !first_reg)) begin
      oe_next = 4'h0;
    end
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      first_reg <= 1'b1;
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      tx_sh_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
      rx_data_reg <= 8'h00;
      rx_first_reg <= 1'b0;
      rx_early_reg <= 1'b0;
      io_lane_out <= 4'h0;
      io_lane_oe_out <= 4'h0;
    end else begin
      io_lane_oe_out <= oe_next;
      if (!sel_s) begin
        first_reg <= 1'b1;
        rx_cnt_reg <= 4'h0;
        tx_cnt_reg <= 4'h0;
      end else if (active && rise) begin
        rx_sh_reg <= rx_sh_next;
        if (byte_done) begin
          rx_cnt_reg <= 4'h0;
          rx_data_reg <= rx_sh_next;
          rx_first_reg <= first_reg;
          rx_early_reg <= ~wr_ready_reg;
          first_reg <= 1'b0;
        end else begin
          rx_cnt_reg <= rx_cnt_next;
        end
      end else if (active && fall && tx_en && !first_reg) begin
        if (data_mode == `MODE_QUAD) begin
          io_lane_out <= tx_word[7:4];
        end else if (data_mode == `MODE_DUAL) begin
          io_lane_out <= {2'h0, tx_word[7:6]};
        end else begin
          io_lane_out <= {2'h0, tx_word[7], 1'b0};
        end
        tx_sh_reg <= tx_word << lane_step(data_mode);
        tx_cnt_reg <= (tx_cnt_reg + lane_step(data_mode)) & 4'h7;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive flags; a new byte wins over a clear in the same cycle.
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_valid_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (byte_done) begin
        rx_valid_reg <= 1'b1;
      end else if (rx_read) begin
        rx_valid_reg <= 1'b0;
      end
      if (byte_done && rx_valid_reg && !rx_read) begin
        overrun_reg <= 1'b1;
      end else if (ovr_clear) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region protection probe.
  reg [18:0] probe_reg;
  wire prot_hit;

  region_protect u_region_protect (
    .addr_in(probe_reg),
    .complement_protect_in(cfg_reg[`CFG_CMP_BIT]),
    .sector_granular_protect_in(cfg_reg[`CFG_SEC_BIT]),
    .top_bottom_select_in(cfg_reg[`CFG_TB_BIT]),
    .block_protect_level_in(cfg_reg[`CFG_BP_LSB +: 3]),
    .hit_out(prot_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire wr_fire;
  wire cfg_locked;
  reg [31:0] rd_mux;
  reg rd_err;
  reg wr_err;
  reg [31:0] wr_val;

  assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_out;
  assign cfg_locked = wp_act & (cfg_reg[`CFG_LOCK_LSB +: 2] != 2'h0);
  assign rx_read = arvalid_in & arready_out & (araddr_in == `RXDATA_OFS);
  assign ovr_clear = wr_fire & (waddr_reg == `STATUS_OFS) &
    wstrb_reg[0] & wdata_reg[`ST_OVR_BIT];

  always @* begin
    wr_err = 1'b0;
    wr_val = 32'h00000000;
    if (waddr_reg == `CTRL_OFS) begin
      wr_val = merge_strb({28'h0000000, ctrl_reg}, wdata_reg, wstrb_reg);
    end else if (waddr_reg == `CONFIG_OFS) begin
      wr_val = merge_strb({23'h000000, cfg_reg}, wdata_reg, wstrb_reg);
      wr_err = cfg_locked;
    end else if (waddr_reg == `TXDATA_OFS) begin
      wr_val = merge_strb({24'h000000, tx_data_reg}, wdata_reg, wstrb_reg);
    end else if (waddr_reg == `PROBE_OFS) begin
      wr_val = merge_strb({13'h0000, probe_reg}, wdata_reg, wstrb_reg);
    end else if (waddr_reg != `STATUS_OFS) begin
      wr_err = 1'b1;
    end
  end

  always @* begin
    rd_err = 1'b0;
    rd_mux = 32'h00000000;
    if (araddr_in == `CTRL_OFS) begin
      rd_mux = {28'h0000000, ctrl_reg};
    end else if (araddr_in == `CONFIG_OFS) begin
      rd_mux = {23'h000000, cfg_reg};
    end else if (araddr_in == `RXDATA_OFS) begin
      rd_mux = {22'h000000, rx_early_reg, rx_first_reg, rx_data_reg};
    end else if (araddr_in == `TXDATA_OFS) begin
      rd_mux = {24'h000000, tx_data_reg};
    end else if (araddr_in == `STATUS_OFS) begin
      rd_mux = {20'h00000, rx_cnt_reg, wp_act, ctrl_reg[`CTRL_BUSY_BIT], overrun_reg,
        wr_ready_reg, pause_act, sel_s, armed_reg, rx_valid_reg};
    end else if (araddr_in == `PROBE_OFS) begin
      rd_mux = {prot_hit | ~wr_ready_reg, 12'h000, probe_reg};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out <= `RESP_OKAY;
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h00000000;
      rresp_out <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
      cfg_reg <= `CONFIG_RESET;
      tx_data_reg <= 8'h00;
      probe_reg <= 19'h00000;
    end else begin
      if (awready_out && awvalid_in) begin
        aw_got_reg <= 1'b1;
        waddr_reg <= {awaddr_in[7:2], 2'h0};
        awready_out <= 1'b0;
      end
      if (wready_out && wvalid_in) begin
        w_got_reg <= 1'b1;
        wdata_reg <= wdata_in;
        wstrb_reg <= wstrb_in;
        wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
        if (!wr_err) begin
          if (waddr_reg == `CTRL_OFS) begin
            // Busy is held by the core only; deselect leaves it alone.
            ctrl_reg <= wr_val[3:0];
          end else if (waddr_reg == `CONFIG_OFS) begin
            cfg_reg <= wr_val[8:0];
          end else if (waddr_reg == `TXDATA_OFS) begin
            tx_data_reg <= wr_val[7:0];
          end else if (waddr_reg == `PROBE_OFS) begin
            probe_reg <= wr_val[18:0];
          end
        end
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
      if (arready_out && arvalid_in) begin
        arready_out <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out <= rd_mux;
        rresp_out <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end
endmodule // serial_nor_pin_interface

// ===== tb/nor_pin_properties.sv
// Purpose: Port-level checks for the serial NOR pin front end.
// Assumes: Only the top module's ports are visible.
// Notes: Bound to the design from the bench file.
`timescale 1ns/1ns
`include "nor_pin_map.vh"
module nor_pin_properties (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire select_n_pin_in,
  input wire sclk_pin_in,
  input wire [3:0] io_lane_out,
  input wire [3:0] io_lane_oe_out,
  input wire awvalid_in,
  input wire awready_out,
  input wire wvalid_in,
  input wire wready_out,
  input wire [1:0] bresp_out,
  input wire bvalid_out,
  input wire bready_in,
  input wire [7:0] araddr_in,
  input wire arvalid_in,
  input wire arready_out,
  input wire [31:0] rdata_out,
  input wire [1:0] rresp_out,
  input wire rvalid_out,
  input wire rready_in
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  sel_float_a: assert property (select_n_pin_in [*6] |-> io_lane_oe_out == 4'h0)
    else $error("lanes driven while deselected");
  oe_legal_a: assert property (io_lane_oe_out inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  lane_edge_a: assert property ($changed(io_lane_out) && io_lane_oe_out != 4'h0 &&
    $past(io_lane_oe_out) != 4'h0 |-> !$past(sclk_pin_in, 2))
    else $error("output lane changed away from a falling edge");
  wr_answer_a: assert property (awvalid_in && awready_out && wvalid_in && wready_out
    |=> ##[0:1] bvalid_out)
    else $error("write response late");
  b_hold_a: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped");
  rd_answer_a: assert property (arvalid_in && arready_out |=> rvalid_out && !arready_out)
    else $error("read response late");
  r_hold_a: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read response dropped");
  rd_unmapped_a: assert property (arvalid_in && arready_out && araddr_in[7:2] > 6'h05
    |=> rresp_out == `RESP_SLVERR && rdata_out == 32'h0)
    else $error("unmapped read not refused");
  cover property (io_lane_oe_out == 4'hf);
  cover property (io_lane_oe_out == 4'h3);
  cover property (bvalid_out && bresp_out == `RESP_SLVERR);
endmodule // nor_pin_properties

// ===== tb/spi_host_model.sv
// Purpose: Host controller model driving select, serial clock and lanes.
// Assumes: Clock idles low; 8 system clocks per serial clock period.
// Notes: Undriven lanes toggle every cycle so no stale value survives.
`timescale 1ns/1ns
module spi_host_model (
  input wire clk_sys_in,
  input wire [3:0] dev_lane_in,
  input wire [3:0] dev_oe_in,
  output logic select_n_out,
  output logic sclk_out,
  output logic [3:0] lane_out
);
  logic [3:0] drv_v = 4'hd;
  logic [3:0] drv_en = 4'hd;
  logic tog = 1'b0;
  // Selection waits 100 us of 40 ns clocks after power-up.
  localparam int select_wait_cyc = 2500;
  int up_cnt = 0;
  initial select_n_out = 1'b1;
  initial sclk_out = 1'b0;
  always @(posedge clk_sys_in) tog <= ~tog;
  always @(posedge clk_sys_in) if (up_cnt < select_wait_cyc) up_cnt <= up_cnt + 1;
  assign lane_out = (dev_oe_in & dev_lane_in) | (~dev_oe_in & drv_en & drv_v) |
    (~dev_oe_in & ~drv_en & {4{tog}});
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic select(input logic lvl);
    @(posedge clk_sys_in);
    while (!lvl && up_cnt < select_wait_cyc) @(posedge clk_sys_in);
    select_n_out <= lvl;
    wait_clk(8);
  endtask
  task automatic pins(input logic wp_n, input logic pause_n);
    @(posedge clk_sys_in);
    drv_v[3:2] <= {pause_n, wp_n};
  endtask
  task automatic drive(input logic [3:0] en);
    @(posedge clk_sys_in);
    drv_en <= en;
  endtask
  // Data moves at the falling edge and is read late in the high half.
  task automatic shift(input logic [7:0] tx, input int n, inout logic [7:0] rx);
    @(posedge clk_sys_in);
    for (int i = 0; i < n; i++) begin
      drv_v[0] <= tx[7 - i];
      wait_clk(4);
      sclk_out <= 1'b1;
      wait_clk(4);
      rx = {rx[6:0], lane_out[1]};
      sclk_out <= 1'b0;
    end
  endtask
endmodule // spi_host_model

// ===== tb/serial_nor_pin_interface_bench.sv
// Purpose: Self-checking bench for the serial NOR pin front end.
// Assumes: Write-ready count shortened to 50 clocks.
// Notes: Registers are reached over AXI4-Lite, pins through the host model.
`timescale 1ns/1ns
`include "nor_pin_map.vh"
module serial_nor_pin_interface_bench;
  logic clk_sys_in = 1'b0;
  logic nrst_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  wire awready, wready, bvalid, arready, rvalid, select_n, sclk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] lane, dev_v, dev_oe;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [7:0] rx, junk;
  always #20 clk_sys_in = ~clk_sys_in;
  serial_nor_pin_interface #(.WRITE_READY_CYCLES(24'd50)) u_serial_nor_pin_interface (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .select_n_pin_in(select_n),
    .sclk_pin_in(sclk), .io_lane_in(lane), .io_lane_out(dev_v), .io_lane_oe_out(dev_oe),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata),
    .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp),
    .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid),
    .rready_in(rready));
  spi_host_model u_spi_host_model (.clk_sys_in(clk_sys_in), .dev_lane_in(dev_v),
    .dev_oe_in(dev_oe), .select_n_out(select_n), .sclk_out(sclk), .lane_out(lane));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys_in);
    n++;
    if (n > 200) begin
      err_total++;
      $display("unexpected at %0t: no bus answer", $time);
      give_verdict();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(dev_oe), 32'h0);
    axi_rd(`CONFIG_OFS, `RESP_OKAY, rd);
    chk(rd, 32'(`CONFIG_RESET));
    axi_rd(`STATUS_OFS, `RESP_OKAY, rd);
    chk(32'(rd[4:1]), 32'h0);
    axi_wr(`PROBE_OFS, 32'h7ffff, `RESP_OKAY);
    @(posedge clk_sys_in);
    wstrb <= 4'h2;
    axi_wr(`PROBE_OFS, 32'h0, `RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(`PROBE_OFS, `RESP_OKAY, rd);
    chk(32'(rd[18:0]), 32'h700ff);
    chk(32'(rd[31]), 32'h1);
    axi_rd(8'h20, `RESP_SLVERR, rd);
    repeat (60) @(posedge clk_sys_in);
    axi_rd(`PROBE_OFS, `RESP_OKAY, rd);
    chk(32'(rd[31]), 32'h0);
  endtask
  task automatic t_frame;
    axi_wr(`TXDATA_OFS, 32'ha5, `RESP_OKAY);
    axi_wr(`CTRL_OFS, 32'h4, `RESP_OKAY);
    u_spi_host_model.select(1'b0);
    u_spi_host_model.shift(8'h3c, 8, rx);
    axi_rd(`RXDATA_OFS, `RESP_OKAY, rd);
    chk(32'(rd[8:0]), 32'h13c);
    u_spi_host_model.shift(8'h96, 8, rx);
    chk(32'(rx), 32'ha5);
    chk(32'(dev_oe), 32'h2);
    axi_rd(`RXDATA_OFS, `RESP_OKAY, rd);
    chk(32'(rd[8:0]), 32'h096);
    u_spi_host_model.select(1'b1);
    chk(32'(dev_oe), 32'h0);
  endtask
  task automatic t_pause;
    axi_wr(`TXDATA_OFS, 32'h3c, `RESP_OKAY);
    u_spi_host_model.select(1'b0);
    u_spi_host_model.shift(8'h81, 8, rx);
    u_spi_host_model.shift(8'hc3, 4, rx);
    u_spi_host_model.pins(1'b1, 1'b0);
    u_spi_host_model.wait_clk(6);
    chk(32'(dev_oe), 32'h0);
    u_spi_host_model.shift(8'h00, 3, junk);
    axi_rd(`STATUS_OFS, `RESP_OKAY, rd);
    chk(32'(rd[3]), 32'h1);
    u_spi_host_model.pins(1'b1, 1'b1);
    u_spi_host_model.wait_clk(4);
    u_spi_host_model.shift(8'h30, 4, rx);
    chk(32'(rx), 32'h3c);
    axi_rd(`RXDATA_OFS, `RESP_OKAY, rd);
    chk(32'(rd[7:0]), 32'hc3);
    axi_rd(`STATUS_OFS, `RESP_OKAY, rd);
    chk(32'(rd[5]), 32'h1);
    axi_wr(`STATUS_OFS, 32'h20, `RESP_OKAY);
    axi_rd(`STATUS_OFS, `RESP_OKAY, rd);
    chk(32'(rd[5]), 32'h0);
    u_spi_host_model.select(1'b1);
  endtask
  task automatic t_modes;
    logic [1:0] md [3] = '{`MODE_DUAL, `MODE_QUAD, `MODE_QUAD};
    logic qe [3] = '{1'b0, 1'b0, 1'b1};
    logic [3:0] eoe [3] = '{4'h3, 4'h2, 4'hf};
    logic [3:0] elo [3] = '{4'h3, 4'h2, 4'hc};
    axi_wr(`TXDATA_OFS, 32'hc5, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      axi_wr(`CONFIG_OFS, 32'(qe[i]), `RESP_OKAY);
      axi_wr(`CTRL_OFS, 32'h4 | 32'(md[i]), `RESP_OKAY);
      u_spi_host_model.pins(1'b1, ~qe[i]);
      u_spi_host_model.select(1'b0);
      u_spi_host_model.shift(8'h5a, 8, rx);
      u_spi_host_model.drive(4'hd & ~eoe[i]);
      u_spi_host_model.wait_clk(6);
      chk(32'(dev_oe), 32'(eoe[i]));
      chk(32'(dev_v), 32'(elo[i]));
      axi_rd(`RXDATA_OFS, `RESP_OKAY, rd);
      chk(32'(rd[8:0]), 32'h15a);
      u_spi_host_model.select(1'b1);
      u_spi_host_model.drive(4'hd);
      u_spi_host_model.pins(1'b1, 1'b1);
    end
  endtask
  task automatic t_lock;
    axi_wr(`CONFIG_OFS, 32'h3, `RESP_OKAY);
    u_spi_host_model.pins(1'b0, 1'b1);
    u_spi_host_model.wait_clk(4);
    axi_wr(`CONFIG_OFS, 32'h2, `RESP_OKAY);
    axi_wr(`CONFIG_OFS, 32'h0, `RESP_SLVERR);
    axi_rd(`CONFIG_OFS, `RESP_OKAY, rd);
    chk(rd, 32'h2);
    u_spi_host_model.pins(1'b1, 1'b1);
    u_spi_host_model.wait_clk(4);
    axi_wr(`CONFIG_OFS, 32'h0, `RESP_OKAY);
  endtask
  task automatic t_region;
    logic [8:0] cf [7] = '{9'h040, 9'h040, 9'h048, 9'h048, 9'h070, 9'h070, 9'h1c0};
    logic [18:0] ad [7] = '{19'h7ffff, 19'h6ffff, 19'h7ffff, 19'h6ffff, 19'h00fff,
      19'h01000, 19'h00000};
    logic bk [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      axi_wr(`CONFIG_OFS, 32'(cf[i]), `RESP_OKAY);
      axi_wr(`PROBE_OFS, 32'(ad[i]), `RESP_OKAY);
      axi_rd(`PROBE_OFS, `RESP_OKAY, rd);
      chk(32'(rd[31]), 32'(bk[i]));
    end
    axi_wr(`CONFIG_OFS, 32'h0, `RESP_OKAY);
  endtask
  task automatic t_busy;
    axi_wr(`CTRL_OFS, 32'h8, `RESP_OKAY);
    u_spi_host_model.select(1'b0);
    u_spi_host_model.shift(8'h06, 8, rx);
    u_spi_host_model.select(1'b1);
    axi_rd(`CTRL_OFS, `RESP_OKAY, rd);
    chk(32'(rd[3]), 32'h1);
    axi_rd(`STATUS_OFS, `RESP_OKAY, rd);
    chk(32'(rd[6]), 32'h1);
  endtask
  initial begin
    nrst_in = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_reset();
    t_frame();
    t_pause();
    t_modes();
    t_lock();
    t_region();
    t_busy();
    give_verdict();
  end
endmodule // serial_nor_pin_interface_bench
bind serial_nor_pin_interface nor_pin_properties u_nor_pin_properties (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .select_n_pin_in(select_n_pin_in),
  .sclk_pin_in(sclk_pin_in), .io_lane_out(io_lane_out), .io_lane_oe_out(io_lane_oe_out),
  .awvalid_in(awvalid_in), .awready_out(awready_out), .wvalid_in(wvalid_in),
  .wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out),
  .bready_in(bready_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in),
  .arready_out(arready_out), .rdata_out(rdata_out), .rresp_out(rresp_out),
  .rvalid_out(rvalid_out), .rready_in(rready_in));
